// ==== dv/icc_top_properties.sv ====
// Port-level assertions for the IR carrier block
`timescale 1ns/1ps
`default_nettype none
module icc_top_properties (
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic [2:0] regAddr,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic       irRxIn,
  input wire logic       infraredTxOut,
  input wire logic       rxEnvelope,
  input wire logic       sel0AsOutput,
  input wire logic       autoConfigEnable,
  input wire logic [2:0] autoModeSelect,
  input wire logic [2:0] dongleModeSelect,
  input wire logic [2:0] dongleModeOe_n,
  input wire logic [7:0] bankSelectMirror,
  input wire logic       rxSamplingSelect,
  input wire logic       rxCarrierRange,
  input wire logic       demodulatorDisable,
  input wire logic       txSubcarrierRange,
  input var icc_pkg::icc_mod_type modulatorMode
);
  import icc_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // ****************
  // Sequences
  // ****************
  sequence s_wr4; regWrite && regAddr == 3'h4; endsequence
  sequence s_lit8; infraredTxOut [*8]; endsequence
  property p_pulse; s_wr4 ##0 regWrData[7] |-> ##2 s_lit8; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse output dropped");
  property p_force;
    s_wr4 ##0 regWrData[5] ##1 !(regWrite && regAddr == 3'h4) |-> ##1 infraredTxOut;
  endproperty
  a_force: assert property (p_force) else $error("force output low");
  property p_cfg;
    regWrite && regAddr == 3'h2 |=> {rxSamplingSelect, rxCarrierRange, demodulatorDisable,
      txSubcarrierRange, modulatorMode} == {$past(regWrData[6:4]), $past(regWrData[2:0])};
  endproperty
  a_cfg: assert property (p_cfg) else $error("config outputs wrong");
  property p_bank; regWrite && regAddr == 3'h3 |=> bankSelectMirror == $past(regWrData);
  endproperty
  a_bank: assert property (p_bank) else $error("bank select wrong");
  property p_rdcfg;
    regRead && !regWrite && regAddr == 3'h2 |=> regRdData[6:0] == {$past(rxSamplingSelect),
      $past(rxCarrierRange), $past(demodulatorDisable), 1'b0, $past(txSubcarrierRange),
      $past(modulatorMode)};
  endproperty
  a_rdcfg: assert property (p_rdcfg) else $error("config readback wrong");
  property p_oe; 1'b1 |=> dongleModeOe_n == {2'b00, !$past(sel0AsOutput)}; endproperty
  a_oe: assert property (p_oe) else $error("select enable wrong");
  property p_ctl;
    s_wr4 ##0 !autoConfigEnable ##1 !autoConfigEnable && !(regWrite && regAddr == 3'h4)
      |=> dongleModeSelect[2:1] == $past(regWrData[2:1], 2) &&
      (!$past(sel0AsOutput, 2) || dongleModeSelect[0] == $past(regWrData[0], 2));
  endproperty
  a_ctl: assert property (p_ctl) else $error("dongle select wrong");
  property p_auto;
    autoConfigEnable ##1 autoConfigEnable |-> dongleModeSelect == $past(autoModeSelect);
  endproperty
  a_auto: assert property (p_auto) else $error("auto select wrong");
  property p_bypass; demodulatorDisable |-> rxEnvelope == $past(irRxIn, 2); endproperty
  a_bypass: assert property (p_bypass) else $error("bypass envelope wrong");
endmodule // icc_top_properties
`default_nettype wire

// ==== dv/icc_xcvr_model.sv ====
// Behavioural IR transceiver: LED, receiver and select pin
`timescale 1ns/1ps
`default_nettype none
module icc_xcvr_model (
  input  wire logic ledOn,
  input  wire logic echoOn,
  input  wire logic ambient,
  input  wire logic selLevel,
  output logic      rxOut,
  output logic      selOut
);
  // receiver sees light level
  // Echo models LED light reflected into the receiver
  assign rxOut = ambient | (echoOn & ledOn);
  assign selOut = selLevel;
endmodule // icc_xcvr_model
`default_nettype wire

// ==== dv/infrared_carrier_config_test.sv ====
// Self-checking bench for the IR carrier block
`timescale 1ns/1ps
`default_nettype none
module infrared_carrier_config_test;
  import icc_pkg::*;
  logic        clock, nrst, regWrite, regRead, txValid, sel0AsOutput, autoConfigEnable;
  logic [2:0]  regAddr, autoModeSelect, dongleModeSelect, dongleModeOe_n, c;
  logic [7:0]  regWrData, regRdData, txData, rxData, bankSelectMirror, d;
  logic        txReady, rxValid, irRxIn, infraredTxOut, rxEnvelope, sel0In;
  logic        rxSamplingSelect, rxCarrierRange, demodulatorDisable, txSubcarrierRange;
  logic        echoOn, ambient, selLevel, rdPend, prevTx;
  icc_mod_type modulatorMode;
  logic [7:0]  expQ[$];
  logic [7:0]  cfgs[5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84};
  int          pulses[5] = '{128, 8, 6, 0, 256};
  logic [2:0]  modes[3] = '{3'b011, 3'b100, 3'b111};
  int          num_errors, n_checks, edges, litCyc, fullRuns, cyc, e0, seedJunk;

  icc_top #(.BIT_CYC(16), .OVS_CYC(1), .CAR_LO_CYC(8), .CAR_HI_CYC(4), .PULSE_CYC(20))
    DUT (.clock(clock), .nrst(nrst), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData),
    .txData(txData), .txValid(txValid), .txReady(txReady), .rxData(rxData),
    .rxValid(rxValid), .irRxIn(irRxIn), .infraredTxOut(infraredTxOut),
    .rxEnvelope(rxEnvelope), .sel0In(sel0In), .sel0AsOutput(sel0AsOutput),
    .autoConfigEnable(autoConfigEnable), .autoModeSelect(autoModeSelect),
    .dongleModeSelect(dongleModeSelect), .dongleModeOe_n(dongleModeOe_n),
    .bankSelectMirror(bankSelectMirror), .rxSamplingSelect(rxSamplingSelect),
    .rxCarrierRange(rxCarrierRange), .demodulatorDisable(demodulatorDisable),
    .txSubcarrierRange(txSubcarrierRange), .modulatorMode(modulatorMode));
  icc_xcvr_model u_xcvr (.ledOn(infraredTxOut), .echoOn(echoOn), .ambient(ambient),
    .selLevel(selLevel), .rxOut(irRxIn), .selOut(sel0In));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (e !== s) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      num_errors++;
    end
  endtask
  task summarize;
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task wr(input logic [2:0] a, input logic [7:0] v);
    @(negedge clock); regAddr = a; regWrData = v; regWrite = 1'b1;
    @(negedge clock); regWrite = 1'b0;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    @(negedge clock); regAddr = a; regRead = 1'b1; expQ.push_back(e);
    @(negedge clock); regRead = 1'b0;
  endtask
  task send(input logic [7:0] v);
    @(negedge clock);
    while (txReady !== 1'b1) @(negedge clock);
    txData = v; txValid = 1'b1;
    @(negedge clock); txValid = 1'b0;
  endtask
  task car(input int per, input int n, input logic e);
    repeat (n) begin
      ambient = 1'b1; repeat (per / 2) @(negedge clock);
      ambient = 1'b0; repeat (per / 2) @(negedge clock);
    end
    chk("rxEnvelope", e, rxEnvelope);
  endtask

  // ****************
  // Monitors
  // ****************
  always @(posedge clock) begin
    rdPend <= regRead;
    prevTx <= infraredTxOut;
    if (infraredTxOut === 1'b1 && prevTx === 1'b0) edges <= edges + 1;
    if (infraredTxOut === 1'b1) litCyc <= litCyc + 1;
    if (rxValid === 1'b1 && rxData === 8'h7f) fullRuns <= fullRuns + 1;
    cyc <= cyc + 1;
    // Hang guard, run needs about 15800 cycles
    if (cyc == 40000) begin num_errors++; summarize(); end
  end
  always @(negedge clock) if (rdPend === 1'b1) chk("regRdData", expQ.pop_front(), regRdData);

  initial begin
    nrst = 0; regAddr = 0; regWrite = 0; regRead = 0; regWrData = 0; txData = 0;
    txValid = 0; sel0AsOutput = 0; autoConfigEnable = 0; autoModeSelect = 0;
    echoOn = 0; ambient = 0; selLevel = 0; rdPend = 0; prevTx = 0;
    seedJunk = $urandom(32'h9ca960de);
    repeat (2) @(negedge clock);
    nrst = 1;
    for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom); wr(3'h2, d); rd(3'h2, d & 8'hf7);
      d = 8'($urandom); wr(3'h3, d); rd(3'h3, d);
      d = 8'($urandom); wr(3'h5, d); rd(3'h5, 8'h00);
    end
    sel0AsOutput = 1; echoOn = 1; c = 3'($urandom);
    wr(3'h4, {5'b01111, c});
    repeat (6) @(negedge clock);
    chk("infraredTxOut", 1'b1, infraredTxOut);
    rd(3'h4, {5'b00110, c});
    wr(3'h4, {5'b00000, c});
    repeat (6) @(negedge clock);
    rd(3'h4, {5'b00000, c});
    sel0AsOutput = 0; selLevel = 1; wr(3'h4, 8'h00);
    repeat (4) @(negedge clock);
    rd(3'h4, 8'h01);
    sel0AsOutput = 1; autoConfigEnable = 1; autoModeSelect = 3'($urandom);
    repeat (3) @(negedge clock);
    chk("dongleModeSelect", autoModeSelect, dongleModeSelect);
    autoConfigEnable = 0;
    for (int i = 0; i < 3; i++) begin
      wr(3'h4, {5'b00000, modes[i]});
      repeat (3) @(negedge clock);
      chk("dongleModeSelect", modes[i], dongleModeSelect);
    end
    echoOn = 0; e0 = litCyc;
    wr(3'h4, 8'h80); rd(3'h4, 8'h80);
    repeat (40) @(negedge clock);
    chk("litCyc", 20, litCyc - e0);
    rd(3'h4, 8'h00);
    // Run codes: one, 64 zeros, ones; last pushes fill the FIFO
    for (int i = 0; i < 5; i++) begin
      wr(3'h2, cfgs[i]); e0 = edges;
      send(8'h80); send(8'h3f); send(8'h80); send(8'h80); send(8'h80);
      chk("txReady", 1'b0, txReady);
      repeat (1200) @(negedge clock);
      chk("edges", pulses[i], edges - e0);
    end
    // Plain byte of zeros: eight bit times, two carrier periods each
    wr(3'h2, 8'h00); e0 = edges; send(8'h00);
    repeat (200) @(negedge clock);
    chk("edges", 16, edges - e0);
    wr(3'h2, 8'hd0); repeat (10) @(negedge clock);
    e0 = fullRuns; ambient = 1; repeat (448) @(negedge clock);
    ambient = 0; repeat (20) @(negedge clock);
    chk("fullRuns", 3, fullRuns - e0);
    wr(3'h2, 8'h00); car(2000, 3, 1'b1);
    car(500, 4, 1'b0);
    wr(3'h2, 8'h20); car(220, 4, 1'b1);
    summarize();
  end
endmodule // infrared_carrier_config_test

bind icc_top icc_top_properties u_props (.clock(clock), .nrst(nrst), .regAddr(regAddr),
  .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData),
  .irRxIn(irRxIn), .infraredTxOut(infraredTxOut), .rxEnvelope(rxEnvelope),
  .sel0AsOutput(sel0AsOutput), .autoConfigEnable(autoConfigEnable),
  .autoModeSelect(autoModeSelect), .dongleModeSelect(dongleModeSelect),
  .dongleModeOe_n(dongleModeOe_n), .bankSelectMirror(bankSelectMirror),
  .rxSamplingSelect(rxSamplingSelect), .rxCarrierRange(rxCarrierRange),
  .demodulatorDisable(demodulatorDisable), .txSubcarrierRange(txSubcarrierRange),
  .modulatorMode(modulatorMode));
`default_nettype wire

// ==== hw/icc_defs.svh ====
// Offsets, field positions, reset values and timing counts of the IR carrier block
// How it works
// - Run-length bit set: transmit bytes are run codes, receive emits run codes.
// - Code byte: MSB is bit value, low seven bits are run length minus one.
// - Sampling bit: 0 samples once per bit time, 1 oversamples.
// - Receive range bit: 0 low carrier window, 1 high carrier window.
// - Demodulator disable bit bypasses the internal demodulator.
// - Enabled demodulator checks carrier spacing and builds the envelope.
// - Transmit range bit: 0 low carrier period, 1 high carrier period.
// - Mode 00: carrier pulses for the whole of every zero bit.
// - Mode 01: eight carrier pulses when zeros follow a one.
// - Mode 10: six carrier pulses when zeros follow a one.
// - Offset 03h is the bank select register itself, reachable here.
// - Offset 04h drives dongle mode unless automatic configuration is on.
// - Low control bit reads the adapter identification pin when it is input.
// - Writing 1 to pulse bit drives transmit high for 64 us, restartable.
// - Force bit holds the transmit output high.
// - Receive level bit reads the synchronised receive input.
// - Control field drives dongle select lines when they are outputs.
`ifndef ICC_DEFS_SVH
`define ICC_DEFS_SVH

`define ICC_OFS_CIR   3'h2
`define ICC_OFS_BANK  3'h3
`define ICC_OFS_XCV   3'h4

`define ICC_B_RLEN    7
`define ICC_B_OVS     6
`define ICC_B_RXHI    5
`define ICC_B_DMDIS   4
`define ICC_B_TXHI    2
`define ICC_B_MMD     0
`define ICC_CIR_WMASK 8'hf7

`define ICC_B_TRIG    7
`define ICC_B_FORCE   5
`define ICC_B_RXLV    4
`define ICC_B_CTL     0

`define ICC_RST_CIR   8'h00
`define ICC_RST_BANK  8'h00
`define ICC_RST_FORCE 1'b0
`define ICC_RST_CTL   3'h0

`define ICC_CLK_MHZ   100
`define ICC_PULSE_US  64
`define ICC_PULSE_CYC (`ICC_PULSE_US * `ICC_CLK_MHZ)

`define ICC_CLK_DKHZ  1000000
`define ICC_LO_FMIN   300
`define ICC_LO_FMAX   569
`define ICC_HI_FMIN   4000
`define ICC_HI_FMAX   4800

`define ICC_BURST8    4'h8
`define ICC_BURST6    4'h6
`define ICC_RUN_MAX   7'h7f

`endif

// ==== hw/icc_fifo.sv ====
// Small synchronous FIFO for transmit bytes
`timescale 1ns/1ps
`default_nettype none
module icc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
)(
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad
      $error("icc_fifo: depth below 2 or zero width");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign inReady  = count_q != (AW+1)'(DEPTH);
  assign outValid = count_q != '0;
  assign outData  = mem[rdPtr_q];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // icc_fifo
`default_nettype wire

// ==== hw/icc_pkg.sv ====
// Types shared by the IR carrier block
package icc_pkg;

  typedef enum logic [1:0] {
    ICC_MOD_CONT  = 2'b00,
    ICC_MOD_EIGHT = 2'b01,
    ICC_MOD_SIX   = 2'b10,
    ICC_MOD_RSVD  = 2'b11
  } icc_mod_type;

  typedef enum logic [1:0] {
    ICC_TX_IDLE = 2'b01,
    ICC_TX_SEND = 2'b10
  } icc_tx_type;

endpackage

// ==== hw/icc_top.sv ====
// Consumer IR configuration, modulator, demodulator and transceiver control
`timescale 1ns/1ps
`default_nettype none
`include "icc_defs.svh"
module icc_top #(
  parameter int BIT_CYC    = 16,
  parameter int OVS_CYC    = 1,
  parameter int CAR_LO_CYC = 2778,
  parameter int CAR_HI_CYC = 222,
  parameter int PULSE_CYC  = `ICC_PULSE_CYC,
  parameter int FIFO_DEPTH = 4
)(
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic [2:0] regAddr,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  input  wire logic [7:0] txData,
  input  wire logic       txValid,
  output logic            txReady,
  output logic      [7:0] rxData,
  output logic            rxValid,
  input  wire logic       irRxIn,
  output logic            infraredTxOut,
  output logic            rxEnvelope,
  input  wire logic       sel0In,
  input  wire logic       sel0AsOutput,
  input  wire logic       autoConfigEnable,
  input  wire logic [2:0] autoModeSelect,
  output logic      [2:0] dongleModeSelect,
  output logic      [2:0] dongleModeOe_n,
  output logic      [7:0] bankSelectMirror,
  output logic            rxSamplingSelect,
  output logic            rxCarrierRange,
  output logic            demodulatorDisable,
  output logic            txSubcarrierRange,
  output icc_pkg::icc_mod_type modulatorMode
);
  import icc_pkg::*;

  localparam int PW = $clog2(PULSE_CYC + 1);
  localparam logic [11:0] LO_GMIN = 12'(`ICC_CLK_DKHZ / `ICC_LO_FMAX);
  localparam logic [11:0] LO_GMAX = 12'(`ICC_CLK_DKHZ / `ICC_LO_FMIN);
  localparam logic [11:0] HI_GMIN = 12'(`ICC_CLK_DKHZ / `ICC_HI_FMAX);
  localparam logic [11:0] HI_GMAX = 12'(`ICC_CLK_DKHZ / `ICC_HI_FMIN);

  generate
    if (BIT_CYC < 2 || OVS_CYC < 1 || BIT_CYC > 65535 || OVS_CYC > 65535 ||
        CAR_LO_CYC < 2 || CAR_HI_CYC < 2 || CAR_LO_CYC > 4095 ||
        CAR_HI_CYC > 4095 || PULSE_CYC < 2 || FIFO_DEPTH < 2) begin : g_bad
      $error("icc_top: parameter out of range");
    end
  endgenerate

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0]    cirCfg_q;
  logic [7:0]    bank_q;
  logic          trig_q;
  logic          force_q;
  logic [2:0]    ctl_q;
  logic [PW-1:0] pulseCnt_q;
  logic [7:0]    rdData_q;
  logic          wrCir;
  logic          wrBank;
  logic          wrXcv;
  logic          rxMeta_q;
  logic          rxSync_q;
  logic          sel0Meta_q;
  logic          sel0Sync_q;

  assign wrCir  = regWrite && (regAddr == `ICC_OFS_CIR);
  assign wrBank = regWrite && (regAddr == `ICC_OFS_BANK);
  assign wrXcv  = regWrite && (regAddr == `ICC_OFS_XCV);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cirCfg_q <= `ICC_RST_CIR;
    end else if (wrCir) begin
      cirCfg_q <= regWrData & `ICC_CIR_WMASK;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bank_q <= `ICC_RST_BANK;
    end else if (wrBank) begin
      bank_q <= regWrData;
    end
  end

  // pin bit ignores writes as input
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      force_q <= `ICC_RST_FORCE;
      ctl_q   <= `ICC_RST_CTL;
    end else if (wrXcv) begin
      force_q    <= regWrData[`ICC_B_FORCE];
      ctl_q[2:1] <= regWrData[`ICC_B_CTL+1 +: 2];
      if (sel0AsOutput) begin
        ctl_q[0] <= regWrData[`ICC_B_CTL];
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      trig_q     <= 1'b0;
      pulseCnt_q <= '0;
    end else if (wrXcv && regWrData[`ICC_B_TRIG]) begin
      trig_q     <= 1'b1;
      pulseCnt_q <= PW'(PULSE_CYC - 1);
    end else if (trig_q) begin
      if (pulseCnt_q == '0) begin
        trig_q <= 1'b0;
      end else begin
        pulseCnt_q <= pulseCnt_q - 1'b1;
      end
    end
  end

  // Pins are asynchronous to the clock
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rxMeta_q   <= 1'b0;
      rxSync_q   <= 1'b0;
      sel0Meta_q <= 1'b0;
      sel0Sync_q <= 1'b0;
    end else begin
      rxMeta_q   <= irRxIn;
      rxSync_q   <= rxMeta_q;
      sel0Meta_q <= sel0In;
      sel0Sync_q <= sel0Meta_q;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdData_q <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `ICC_OFS_CIR:  rdData_q <= cirCfg_q;
        `ICC_OFS_BANK: rdData_q <= bank_q;
        `ICC_OFS_XCV:  rdData_q <= {trig_q, 1'b0, force_q, rxSync_q, 1'b0,
                                    ctl_q[2:1],
                                    sel0AsOutput ? ctl_q[0] : sel0Sync_q};
        default:       rdData_q <= 8'h00;
      endcase
    end
  end

  assign regRdData          = rdData_q;
  assign bankSelectMirror   = bank_q;
  assign rxSamplingSelect   = cirCfg_q[`ICC_B_OVS];
  assign rxCarrierRange     = cirCfg_q[`ICC_B_RXHI];
  assign demodulatorDisable = cirCfg_q[`ICC_B_DMDIS];
  assign txSubcarrierRange  = cirCfg_q[`ICC_B_TXHI];
  assign modulatorMode      = icc_mod_type'(cirCfg_q[`ICC_B_MMD +: 2]);

  // ****************************************
  // Dongle select lines
  // ****************************************
  logic [2:0] donSel_q;
  logic [2:0] donOe_n_q;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      donSel_q  <= 3'h0;
      donOe_n_q <= 3'h1;
    end else begin
      donSel_q  <= autoConfigEnable ? autoModeSelect : ctl_q;
      donOe_n_q <= {2'b00, !sel0AsOutput};
    end
  end

  assign dongleModeSelect = donSel_q;
  assign dongleModeOe_n   = donOe_n_q;

  // ****************************************
  // Receive demodulator
  // ****************************************
  logic        rxPrev_q;
  logic [11:0] gap_q;
  logic        env_q;
  logic [11:0] gMin;
  logic [11:0] gMax;
  logic        rxRise;
  logic        envelope;

  assign gMin   = rxCarrierRange ? HI_GMIN : LO_GMIN;
  assign gMax   = rxCarrierRange ? HI_GMAX : LO_GMAX;
  assign rxRise = rxSync_q && !rxPrev_q;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rxPrev_q <= 1'b0;
      gap_q    <= 12'hfff;
      env_q    <= 1'b0;
    end else begin
      rxPrev_q <= rxSync_q;
      if (rxRise) begin
        env_q <= (gap_q >= gMin) && (gap_q <= gMax);
        gap_q <= 12'h000;
      end else begin
        if (gap_q != 12'hfff) begin
          gap_q <= gap_q + 1'b1;
        end
        if (gap_q > gMax) begin
          env_q <= 1'b0;
        end
      end
    end
  end

  assign envelope   = demodulatorDisable ? rxSync_q : env_q;
  assign rxEnvelope = envelope;

  // ****************************************
  // Receive sampler and byte builder
  // ****************************************
  logic [15:0] sampCnt_q;
  logic        sampTick;
  logic        rxBit;
  logic [7:0]  rxShift_q;
  logic [2:0]  rxCount_q;
  logic        runVal_q;
  logic [6:0]  runCnt_q;
  logic        runHave_q;
  logic [7:0]  rxData_q;
  logic        rxValid_q;

  assign sampTick = sampCnt_q == 16'h0000;
  // Carrier present means a zero bit
  assign rxBit    = !envelope;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sampCnt_q <= 16'h0000;
    end else if (sampTick) begin
      sampCnt_q <= rxSamplingSelect ? 16'(OVS_CYC - 1) : 16'(BIT_CYC - 1);
    end else begin
      sampCnt_q <= sampCnt_q - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rxShift_q <= 8'h00;
      rxCount_q <= 3'h0;
      runVal_q  <= 1'b0;
      runCnt_q  <= 7'h00;
      runHave_q <= 1'b0;
      rxData_q  <= 8'h00;
      rxValid_q <= 1'b0;
    end else begin
      rxValid_q <= 1'b0;
      if (!cirCfg_q[`ICC_B_RLEN]) begin
        runHave_q <= 1'b0;
      end
      if (sampTick) begin
        if (cirCfg_q[`ICC_B_RLEN]) begin
          if (!runHave_q) begin
            runHave_q <= 1'b1;
            runVal_q  <= rxBit;
            runCnt_q  <= 7'h00;
          end else if (rxBit == runVal_q && runCnt_q != `ICC_RUN_MAX) begin
            runCnt_q <= runCnt_q + 1'b1;
          end else begin
            rxData_q  <= {runVal_q, runCnt_q};
            rxValid_q <= 1'b1;
            runVal_q  <= rxBit;
            runCnt_q  <= 7'h00;
          end
        end else begin
          rxShift_q <= {rxBit, rxShift_q[7:1]};
          rxCount_q <= rxCount_q + 1'b1;
          if (rxCount_q == 3'h7) begin
            rxData_q  <= {rxBit, rxShift_q[7:1]};
            rxValid_q <= 1'b1;
          end
        end
      end
    end
  end

  assign rxData  = rxData_q;
  assign rxValid = rxValid_q;

  // ****************************************
  // Transmit buffer and serialiser
  // ****************************************
  logic [7:0]  fData;
  logic        fValid;
  logic        fReady;
  icc_tx_type  state_q;
  logic [15:0] bitCnt_q;
  logic [6:0]  bitsLeft_q;
  logic [7:0]  txShift_q;
  logic        rleBit_q;
  logic        rleMode_q;
  logic        bitEnd;
  logic        lastBit;
  logic        take;
  logic        curBit;

  // Deeper buffering only hides software latency
  icc_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock    (clock),
    .nrst     (nrst),
    .inData   (txData),
    .inValid  (txValid),
    .inReady  (txReady),
    .outData  (fData),
    .outValid (fValid),
    .outReady (fReady)
  );

  assign bitEnd  = (state_q == ICC_TX_SEND) && (bitCnt_q == 16'h0000);
  assign lastBit = bitEnd && (bitsLeft_q == 7'h00);
  assign fReady  = (state_q == ICC_TX_IDLE) || lastBit;
  assign take    = fValid && fReady;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q    <= ICC_TX_IDLE;
      bitCnt_q   <= 16'h0000;
      bitsLeft_q <= 7'h00;
      txShift_q  <= 8'hff;
      rleBit_q   <= 1'b1;
      rleMode_q  <= 1'b0;
    end else begin
      case (state_q)
        ICC_TX_IDLE, ICC_TX_SEND: begin
          if (take) begin
            state_q   <= ICC_TX_SEND;
            bitCnt_q  <= 16'(BIT_CYC - 1);
            rleMode_q <= cirCfg_q[`ICC_B_RLEN];
            if (cirCfg_q[`ICC_B_RLEN]) begin
              rleBit_q   <= fData[7];
              bitsLeft_q <= fData[6:0];
            end else begin
              txShift_q  <= fData;
              bitsLeft_q <= 7'h07;
            end
          end else if (lastBit) begin
            state_q <= ICC_TX_IDLE;
          end else if (bitEnd) begin
            bitCnt_q   <= 16'(BIT_CYC - 1);
            bitsLeft_q <= bitsLeft_q - 1'b1;
            txShift_q  <= {1'b1, txShift_q[7:1]};
          end else if (state_q == ICC_TX_SEND) begin
            bitCnt_q <= bitCnt_q - 1'b1;
          end
        end
        default: begin
          state_q <= ICC_TX_IDLE;
        end
      endcase
    end
  end

  // Idle line is a one, so no light
  assign curBit = (state_q != ICC_TX_SEND) ? 1'b1 :
                  (rleMode_q ? rleBit_q : txShift_q[0]);

  // ****************************************
  // Modulator
  // ****************************************
  logic        prevBit_q;
  logic        fall;
  logic [11:0] carCnt_q;
  logic [11:0] carPer;
  logic        carWrap;
  logic        wave;
  logic [3:0]  burst_q;
  logic        modOut;
  logic        txOut_q;

  assign carPer  = txSubcarrierRange ? 12'(CAR_HI_CYC) : 12'(CAR_LO_CYC);
  assign carWrap = carCnt_q >= carPer - 1'b1;
  assign wave    = carCnt_q < (carPer >> 1);
  assign fall    = prevBit_q && !curBit;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prevBit_q <= 1'b1;
      carCnt_q  <= 12'h000;
    end else begin
      prevBit_q <= curBit;
      if (fall || carWrap) begin
        carCnt_q <= 12'h000;
      end else begin
        carCnt_q <= carCnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      burst_q <= 4'h0;
    end else if (fall) begin
      case (modulatorMode)
        ICC_MOD_EIGHT: burst_q <= `ICC_BURST8;
        ICC_MOD_SIX:   burst_q <= `ICC_BURST6;
        default:       burst_q <= 4'h0;
      endcase
    end else if (carWrap && burst_q != 4'h0) begin
      burst_q <= burst_q - 1'b1;
    end
  end

  always_comb begin
    case (modulatorMode)
      ICC_MOD_CONT:  modOut = !curBit && wave;
      ICC_MOD_EIGHT: modOut = (burst_q != 4'h0) && wave;
      ICC_MOD_SIX:   modOut = (burst_q != 4'h0) && wave;
      default:       modOut = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      txOut_q <= 1'b0;
    end else begin
      txOut_q <= force_q || trig_q || modOut;
    end
  end

  assign infraredTxOut = txOut_q;
endmodule // icc_top
`default_nettype wire
